// ---- verilog/delay_search_pkg.sv ----
package delay_search_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SEARCH_CTRL = 8'h2f;
  localparam logic [7:0] ADDR_DUTY_CTRL   = 8'h30;
  localparam logic [7:0] RST_SEARCH_CTRL  = 8'h0b;
  localparam logic [7:0] RST_DUTY_CTRL    = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_EXACT     = 7;
  localparam int BIT_SRCH_ERR  = 6;
  localparam int BIT_TRK_ERR   = 5;
  localparam int GB_MSB        = 4;
  localparam int GB_LSB        = 0;
  localparam int BIT_DUTY_EN   = 7;
  localparam int BIT_STEP_DIR  = 6;
  localparam int TRIM_MSB      = 5;
  localparam int TRIM_LSB      = 0;

  // ----------------------------------------------------------------
  // Search figures and modes
  // ----------------------------------------------------------------
  localparam int GB_SCALE      = 8;
  localparam int NEAR_TOL      = 2;
  localparam logic [1:0] MODE_SRCH_TRACK = 2'h0;
  localparam logic [1:0] MODE_TRACK_ONLY = 2'h1;
  localparam logic [1:0] MODE_SRCH_ONLY  = 2'h2;
  localparam logic [1:0] MODE_INVALID    = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ    = 100;
  localparam int SETTLE_NS  = 50;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

endpackage : delay_search_pkg

// ---- verilog/phase_in_sync.sv ----
`timescale 1ns/1ps
module phase_in_sync #(
  parameter int W = 4
) (
  // Clock, reset, enable
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         ce_i,
  // Data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (ce_i) begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a new value only once two stages agree
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_o <= '0;
    end else if (ce_i && (s2_r == s3_r)) begin
      sync_o <= s3_r;
    end
  end

endmodule : phase_in_sync

// ---- verilog/delay_phase_search_control.sv ----
`timescale 1ns/1ps
module delay_phase_search_control #(
  parameter int DLY_W = 8,
  parameter int PH_W  = 4
) (
  // Clock, reset, enable
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             ce_i,
  // Configuration port
  input  wire logic [7:0]       cfg_addr_i,
  input  wire logic [7:0]       cfg_wdata_i,
  input  wire logic             cfg_wr_i,
  output logic      [7:0]       cfg_rdata_o,
  // Loop control
  input  wire logic             delay_loop_on_i,
  input  wire logic [1:0]       loop_mode_i,
  input  wire logic             lock_snapshot_trigger_i,
  input  wire logic [PH_W-1:0]  target_phase_i,
  input  wire logic [PH_W-1:0]  phase_meas_i,
  // Delay line and analog controls
  output logic      [DLY_W-1:0] delay_code_o,
  output logic                  duty_fix_on_o,
  output logic                  factory_step_direction_o,
  output logic      [5:0]       factory_manual_trim_o,
  // Status
  output logic                  locked_o,
  output logic                  search_failed_o,
  output logic      [DLY_W-1:0] locked_delay_code_o,
  output logic      [PH_W-1:0]  locked_phase_value_o
);
  import delay_search_pkg::*;

  typedef enum logic [2:0] {S_OFF, S_SEARCH, S_TRACK, S_HOLD, S_FAIL} st_t;
  typedef enum logic [1:0] {D_ALT, D_UP, D_DN, D_WIDE} dir_t;

  localparam logic [DLY_W-1:0] CODE_MAX = {DLY_W{1'b1}};
  localparam logic [DLY_W-1:0] CENTER   = DLY_W'(1) << (DLY_W - 1);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] srch_ctrl_r;
  logic [7:0] duty_ctrl_r;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      srch_ctrl_r <= RST_SEARCH_CTRL;
      duty_ctrl_r <= RST_DUTY_CTRL;
    end else if (ce_i && cfg_wr_i) begin
      if (cfg_addr_i == ADDR_SEARCH_CTRL) srch_ctrl_r <= cfg_wdata_i;
      if (cfg_addr_i == ADDR_DUTY_CTRL)   duty_ctrl_r <= cfg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      case (cfg_addr_i)
        ADDR_SEARCH_CTRL: cfg_rdata_o <= srch_ctrl_r;
        ADDR_DUTY_CTRL:   cfg_rdata_o <= duty_ctrl_r;
        default:          cfg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Factory bits are stored and passed on untouched
  assign duty_fix_on_o            = duty_ctrl_r[BIT_DUTY_EN];
  assign factory_step_direction_o = duty_ctrl_r[BIT_STEP_DIR];
  assign factory_manual_trim_o    = duty_ctrl_r[TRIM_MSB:TRIM_LSB];

  // ----------------------------------------------------------------
  // Phase compare
  // ----------------------------------------------------------------
  logic [PH_W-1:0]  meas;
  logic [PH_W-1:0]  diff;
  logic             exact;
  logic             phase_ok;
  logic [DLY_W-1:0] margin;

  phase_in_sync #(.W(PH_W)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .async_i   (phase_meas_i),
    .sync_o    (meas)
  );

  assign exact = srch_ctrl_r[BIT_EXACT];
  assign diff  = (meas > target_phase_i) ? meas - target_phase_i
                                         : target_phase_i - meas;
  assign phase_ok = exact ? (diff == '0)
                          : (diff <= PH_W'(NEAR_TOL));
  assign margin = DLY_W'(srch_ctrl_r[GB_MSB:GB_LSB]) * DLY_W'(GB_SCALE);

  // ----------------------------------------------------------------
  // Step timer
  // ----------------------------------------------------------------
  logic [7:0] settle_r;
  logic       step_now;
  st_t        st_r;

  assign step_now = ce_i && (settle_r == 8'h00);

  // Gives the delay line and phase detector time to settle per step
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      settle_r <= 8'(SETTLE_CYC - 1);
    end else if (ce_i) begin
      if (st_r == S_OFF || settle_r == 8'h00) settle_r <= 8'(SETTLE_CYC - 1);
      else settle_r <= settle_r - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Search and track engine
  // ----------------------------------------------------------------
  dir_t             dir_r;
  logic             turn_r;
  logic [DLY_W-1:0] code_r;
  logic [DLY_W-1:0] up_r;
  logic [DLY_W-1:0] dn_r;
  logic             locked_r;
  logic             failed_r;
  logic [DLY_W-1:0] lim_lo;
  logic [DLY_W-1:0] lim_hi;
  logic             up_blk;
  logic             dn_blk;
  logic             go_up;
  logic             at_end;
  logic             trk_dn;
  logic             run_ok;

  assign run_ok = delay_loop_on_i && (loop_mode_i != MODE_INVALID);
  assign lim_lo = (dir_r == D_WIDE) ? '0 : margin;
  assign lim_hi = (dir_r == D_WIDE) ? CODE_MAX : CODE_MAX - margin;
  assign up_blk = up_r >= lim_hi;
  assign dn_blk = dn_r <= lim_lo;
  assign go_up  = (dir_r == D_UP) || ((dir_r != D_DN) && turn_r);
  assign at_end = (code_r == '0) || (code_r == CODE_MAX);
  assign trk_dn = meas > target_phase_i;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r     <= S_OFF;
      dir_r    <= D_ALT;
      turn_r   <= 1'b1;
      code_r   <= CENTER;
      up_r     <= CENTER;
      dn_r     <= CENTER;
      locked_r <= 1'b0;
      failed_r <= 1'b0;
    end else if (ce_i) begin
      if (!run_ok) begin
        st_r     <= S_OFF;
        locked_r <= 1'b0;
      end else begin
        case (st_r)
          S_OFF: begin
            failed_r <= 1'b0;
            code_r   <= CENTER;
            up_r     <= CENTER;
            dn_r     <= CENTER;
            dir_r    <= D_ALT;
            turn_r   <= 1'b1;
            st_r     <= (loop_mode_i == MODE_TRACK_ONLY) ? S_TRACK
                                                         : S_SEARCH;
          end
          S_SEARCH: if (step_now) begin
            if (phase_ok) begin
              locked_r <= 1'b1;
              st_r     <= (loop_mode_i == MODE_SRCH_ONLY) ? S_HOLD
                                                          : S_TRACK;
            end else if (at_end) begin
              failed_r <= 1'b1;
              if (srch_ctrl_r[BIT_SRCH_ERR]) begin
                code_r <= CENTER;
                up_r   <= CENTER;
                dn_r   <= CENTER;
                dir_r  <= D_ALT;
                turn_r <= 1'b1;
              end else begin
                st_r <= S_FAIL;
              end
            end else begin
              case (dir_r)
                D_ALT, D_WIDE: begin
                  turn_r <= ~turn_r;
                  if (go_up && up_blk && dir_r == D_ALT) dir_r <= D_DN;
                  else if (!go_up && dn_blk && dir_r == D_ALT) dir_r <= D_UP;
                  else if (go_up && !up_blk) begin
                    up_r   <= up_r + DLY_W'(1);
                    code_r <= up_r + DLY_W'(1);
                  end else if (!go_up && !dn_blk) begin
                    dn_r   <= dn_r - DLY_W'(1);
                    code_r <= dn_r - DLY_W'(1);
                  end
                end
                D_UP: begin
                  if (up_blk) dir_r <= D_WIDE;
                  else begin
                    up_r   <= up_r + DLY_W'(1);
                    code_r <= up_r + DLY_W'(1);
                  end
                end
                D_DN: begin
                  if (dn_blk) dir_r <= D_WIDE;
                  else begin
                    dn_r   <= dn_r - DLY_W'(1);
                    code_r <= dn_r - DLY_W'(1);
                  end
                end
                default: dir_r <= D_ALT;
              endcase
            end
          end
          S_TRACK: if (step_now) begin
            locked_r <= phase_ok;
            if (!phase_ok) begin
              if ((trk_dn && code_r == '0) ||
                  (!trk_dn && code_r == CODE_MAX)) begin
                failed_r <= 1'b1;
                if (srch_ctrl_r[BIT_TRK_ERR]) st_r <= S_OFF;
              end else if (trk_dn) begin
                code_r <= code_r - DLY_W'(1);
              end else begin
                code_r <= code_r + DLY_W'(1);
              end
            end
          end
          S_HOLD:  st_r <= S_HOLD;
          S_FAIL:  locked_r <= 1'b0;
          default: st_r <= S_OFF;
        endcase
      end
    end
  end

  assign delay_code_o    = code_r;
  assign locked_o        = locked_r;
  assign search_failed_o = failed_r;

  // ----------------------------------------------------------------
  // Lock snapshot
  // ----------------------------------------------------------------
  logic snap_q_r;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      snap_q_r             <= 1'b0;
      locked_delay_code_o  <= '0;
      locked_phase_value_o <= '0;
    end else if (ce_i) begin
      snap_q_r <= lock_snapshot_trigger_i;
      if (lock_snapshot_trigger_i && !snap_q_r) begin
        locked_delay_code_o  <= code_r;
        locked_phase_value_o <= meas;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_exact;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (ce_i && st_r == S_SEARCH && step_now && exact && diff != '0)
      |=> !locked_r;
  endproperty
  a_exact: assert property (p_exact)
    else $error("Inexact phase locked in exact mode");

  property p_srch_stop;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (run_ok && st_r == S_SEARCH && step_now && !phase_ok && at_end &&
     !srch_ctrl_r[BIT_SRCH_ERR]) |=> st_r == S_FAIL;
  endproperty
  a_srch_stop: assert property (p_srch_stop)
    else $error("Search did not stop on error");

  property p_trk_reset;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (run_ok && st_r == S_TRACK && step_now && !phase_ok &&
     srch_ctrl_r[BIT_TRK_ERR] &&
     ((code_r == CODE_MAX && !trk_dn) || (code_r == '0 && trk_dn)))
      |=> st_r == S_OFF ##1 code_r == CENTER;
  endproperty
  a_trk_reset: assert property (p_trk_reset)
    else $error("Track miss did not reset controller");

  property p_guard;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (st_r == S_SEARCH && dir_r == D_ALT && margin < CENTER)
      |-> (code_r >= margin && code_r <= CODE_MAX - margin);
  endproperty
  a_guard: assert property (p_guard)
    else $error("Alternating search left the guard band");

  property p_one_way;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (run_ok && st_r == S_SEARCH && dir_r == D_DN && !at_end)
      |=> code_r <= $past(code_r);
  endproperty
  a_one_way: assert property (p_one_way)
    else $error("One-way search stepped upward");

  property p_widen;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (run_ok && st_r == S_SEARCH && step_now && !phase_ok && !at_end &&
     ((dir_r == D_UP && up_blk) || (dir_r == D_DN && dn_blk)))
      |=> dir_r == D_WIDE;
  endproperty
  a_widen: assert property (p_widen)
    else $error("Search did not widen after second guard hit");

  property p_end_fail;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (run_ok && st_r == S_SEARCH && step_now && !phase_ok && at_end)
      |=> search_failed_o;
  endproperty
  a_end_fail: assert property (p_end_fail)
    else $error("Endpoint reached without failure flag");

  property p_duty;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (ce_i && cfg_wr_i && cfg_addr_i == ADDR_DUTY_CTRL)
      |=> duty_fix_on_o == $past(cfg_wdata_i[BIT_DUTY_EN]);
  endproperty
  a_duty: assert property (p_duty)
    else $error("Duty correction enable not applied");

  property p_off;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (ce_i && !run_ok) |=> (st_r == S_OFF && !locked_o);
  endproperty
  a_off: assert property (p_off)
    else $error("Controller running while disabled or mode invalid");

  property p_snap;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (ce_i && lock_snapshot_trigger_i && !snap_q_r)
      |=> locked_delay_code_o == $past(code_r);
  endproperty
  a_snap: assert property (p_snap)
    else $error("Snapshot did not capture delay code");

  property p_flags;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (st_r == S_FAIL) |-> (search_failed_o && !locked_o);
  endproperty
  a_flags: assert property (p_flags)
    else $error("Failed state flags inconsistent");

endmodule : delay_phase_search_control

// ---- test/delay_phase_search_control_bench.sv ----
`timescale 1ns/1ps
module delay_phase_search_control_bench;
  import delay_search_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic       sys_clk_i               = 1'b0;
  logic       rstn_i                  = 1'b0;
  logic       ce_i                    = 1'b1;
  logic [7:0] cfg_addr_i              = 8'h00;
  logic [7:0] cfg_wdata_i             = 8'h00;
  logic       cfg_wr_i                = 1'b0;
  logic       delay_loop_on_i         = 1'b0;
  logic [1:0] loop_mode_i             = 2'h0;
  logic       lock_snapshot_trigger_i = 1'b0;
  logic [3:0] target_phase_i          = 4'h4;
  logic [3:0] phase_meas_i            = 4'hc;
  logic [7:0] cfg_rdata_o;
  logic [7:0] delay_code_o;
  logic       duty_fix_on_o;
  logic       factory_step_direction_o;
  logic [5:0] factory_manual_trim_o;
  logic       locked_o;
  logic       search_failed_o;
  logic [7:0] locked_delay_code_o;
  logic [3:0] locked_phase_value_o;
  logic [7:0] goal_code = 8'h84;
  logic       near_only = 1'b0;
  logic [7:0] max_code  = 8'h00;
  int         bad_count = 0;
  int         tests_run = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  // Phase seen by the loop: target (target+2 if near_only) only at the goal code, far elsewhere
  always @(negedge sys_clk_i) begin
    if (delay_code_o === goal_code) begin
      phase_meas_i <= near_only ? target_phase_i + 4'h2 : target_phase_i;
    end else begin
      phase_meas_i <= target_phase_i + 4'h8;
    end
  end

  delay_phase_search_control #(
    .DLY_W (8),
    .PH_W  (4)
  ) delay_phase_search_control_inst (
    .sys_clk_i                (sys_clk_i),
    .rstn_i                   (rstn_i),
    .ce_i                     (ce_i),
    .cfg_addr_i               (cfg_addr_i),
    .cfg_wdata_i              (cfg_wdata_i),
    .cfg_wr_i                 (cfg_wr_i),
    .cfg_rdata_o              (cfg_rdata_o),
    .delay_loop_on_i          (delay_loop_on_i),
    .loop_mode_i              (loop_mode_i),
    .lock_snapshot_trigger_i  (lock_snapshot_trigger_i),
    .target_phase_i           (target_phase_i),
    .phase_meas_i             (phase_meas_i),
    .delay_code_o             (delay_code_o),
    .duty_fix_on_o            (duty_fix_on_o),
    .factory_step_direction_o (factory_step_direction_o),
    .factory_manual_trim_o    (factory_manual_trim_o),
    .locked_o                 (locked_o),
    .search_failed_o          (search_failed_o),
    .locked_delay_code_o      (locked_delay_code_o),
    .locked_phase_value_o     (locked_phase_value_o)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk1

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk_i);
    cfg_addr_i  = addr;
    cfg_wdata_i = data;
    cfg_wr_i    = 1'b1;
    @(negedge sys_clk_i);
    cfg_wr_i    = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge sys_clk_i);
    cfg_addr_i = addr;
    @(negedge sys_clk_i);
    chk8(cfg_rdata_o, exp, "read data");
  endtask : rd_chk

  // Which: 0 locked, 1 failed, 2 code back at centre
  task automatic wait_for(input int which, input int lim);
    int   n;
    logic hit;
    n   = 0;
    hit = 1'b0;
    while (!hit && n < lim) begin
      @(negedge sys_clk_i);
      n++;
      if (delay_code_o > max_code) max_code = delay_code_o;
      case (which)
        0:       hit = (locked_o === 1'b1);
        1:       hit = (search_failed_o === 1'b1);
        default: hit = (delay_code_o === 8'h80);
      endcase
    end
    if (!hit) begin
      bad_count++;
      $display("[FAIL] %0t wait %0d ran out", $time, which);
      print_verdict();
    end
  endtask : wait_for

  // Stop the loop, reconfigure, restart it
  task automatic run(input logic [7:0] cfg, input logic [1:0] mode,
                     input logic [7:0] goal, input logic near);
    @(negedge sys_clk_i);
    delay_loop_on_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    wr(ADDR_SEARCH_CTRL, cfg);
    goal_code       = goal;
    near_only       = near;
    loop_mode_i     = mode;
    max_code        = 8'h00;
    delay_loop_on_i = 1'b1;
  endtask : run

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_regs();
    rd_chk(ADDR_SEARCH_CTRL, RST_SEARCH_CTRL);
    rd_chk(ADDR_DUTY_CTRL, RST_DUTY_CTRL);
    rd_chk(8'h31, 8'h00);
    chk8(delay_code_o, 8'h80, "idle code");
    wr(ADDR_DUTY_CTRL, 8'h7f);
    chk1(duty_fix_on_o, 1'b0, "duty off");
    chk1(factory_step_direction_o, 1'b1, "step dir");
    chk8({2'h0, factory_manual_trim_o}, 8'h3f, "trim");
    wr(ADDR_DUTY_CTRL, 8'h80);
    chk1(duty_fix_on_o, 1'b1, "duty on");
    chk8({2'h0, factory_manual_trim_o}, 8'h00, "trim clear");
    rd_chk(ADDR_DUTY_CTRL, 8'h80);
    wr(ADDR_SEARCH_CTRL, 8'he5);
    rd_chk(ADDR_SEARCH_CTRL, 8'he5);
  endtask : sc_regs

  task automatic sc_exact_lock();
    run(8'h8b, MODE_SRCH_ONLY, 8'h84, 1'b0);
    wait_for(0, 3000);
    chk8(delay_code_o, 8'h84, "exact lock code");
    chk1(search_failed_o, 1'b0, "no fail");
    lock_snapshot_trigger_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    lock_snapshot_trigger_i = 1'b0;
    chk8(locked_delay_code_o, 8'h84, "snap code");
    chk8({4'h0, locked_phase_value_o}, 8'h04, "snap phase");
    loop_mode_i = MODE_INVALID;
    repeat (2) @(negedge sys_clk_i);
    chk1(locked_o, 1'b0, "invalid mode off");
  endtask : sc_exact_lock

  task automatic sc_near_lock();
    run(8'h0b, MODE_SRCH_ONLY, 8'h7c, 1'b1);
    wait_for(0, 3000);
    chk8(delay_code_o, 8'h7c, "near lock code");
    delay_loop_on_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk1(locked_o, 1'b0, "loop off");
  endtask : sc_near_lock

  task automatic sc_fail_policies();
    logic [7:0] held;
    run(8'h80, MODE_SRCH_ONLY, 8'h90, 1'b1);
    wait_for(1, 4000);
    held = delay_code_o;
    chk1((held === 8'h00) || (held === 8'hff), 1'b1, "endpoint");
    chk1(locked_o, 1'b0, "fail unlocked");
    repeat (20) @(negedge sys_clk_i);
    chk8(delay_code_o, held, "stop on error");
    run(8'hc0, MODE_SRCH_ONLY, 8'h90, 1'b1);
    wait_for(1, 4000);
    wait_for(2, 10);
    chk1(search_failed_o, 1'b1, "fail sticky");
  endtask : sc_fail_policies

  task automatic sc_guard();
    run(8'h81, MODE_SRCH_TRACK, 8'h03, 1'b0);
    wait_for(0, 6000);
    chk8(delay_code_o, 8'h03, "lock past guard");
    chk1(search_failed_o, 1'b0, "guard no fail");
    chk1(max_code >= 8'hf7 && max_code <= 8'hfb, 1'b1, "upper guard");
    repeat (20) @(negedge sys_clk_i);
    chk8(delay_code_o, 8'h03, "track holds");
  endtask : sc_guard

  task automatic sc_track();
    run(8'h0b, MODE_TRACK_ONLY, 8'hff, 1'b0);
    wait_for(1, 3000);
    repeat (10) @(negedge sys_clk_i);
    chk8(delay_code_o, 8'h00, "track continue");
    run(8'h2b, MODE_TRACK_ONLY, 8'hff, 1'b0);
    wait_for(1, 3000);
    wait_for(2, 20);
  endtask : sc_track

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    sc_regs();
    sc_exact_lock();
    sc_near_lock();
    sc_fail_policies();
    sc_guard();
    sc_track();
    print_verdict();
  end

endmodule : delay_phase_search_control_bench
